// >>> hw/flfr_regs.vh
/*
  Register offsets, field positions, reset values and codes of the
  FIFO level and frame reset control block.
  Assumes an 8-bit register port with byte addresses as decoded here.
*/
`ifndef FLFR_REGS_VH
`define FLFR_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define FLFR_ADDR_FRAME_CTRL 8'h22
`define FLFR_ADDR_LEVEL_REQ 8'h23
`define FLFR_ADDR_LEVEL_RPT 8'h24
`define FLFR_ADDR_FIFO_CTRL 8'h25

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FLFR_RST_FRAME_CTRL 8'h12
`define FLFR_RST_REPEAT 1'b0
`define FLFR_RST_LEVEL_REQ 8'h40
`define FLFR_RST_TARGET 2'h2
`define FLFR_RST_INT_LEVEL 3'h4
`define FLFR_RST_FRAC_LEVEL 3'h0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FLFR_FRAME_ACK_BIT 3
`define FLFR_REPEAT_BIT 2
`define FLFR_TARGET_HI 1
`define FLFR_TARGET_LO 0
`define FLFR_INT_HI 6
`define FLFR_INT_LO 4
`define FLFR_FRAC_HI 2
`define FLFR_FRAC_LO 0
`define FLFR_HOST_REQ_BIT 0
`define FLFR_HOST_ACK_BIT 1

// ----------------------------------------------------------------
// reset target and interpolation codes
// ----------------------------------------------------------------
`define FLFR_TGT_FIFO 2'h0
`define FLFR_TGT_OSC 2'h1
`define FLFR_TGT_BOTH 2'h2
`define FLFR_TGT_NONE 2'h3
`define FLFR_INTERP_2X 2'h0
`define FLFR_INTERP_4X 2'h2
`define FLFR_INTERP_8X 2'h3

`endif

// >>> hw/flfr_sync2.v
/*
  Two flip-flop synchroniser for a single level.
  Assumes the input may change at any time relative to clk_i.
*/
`timescale 1ns/10ps
`default_nettype none

module flfr_sync2 (
  input wire clk_i,      // clock
  input wire resetn_i,   // async reset, active low
  input wire d_i,        // asynchronous level
  output reg q_o         // synchronised level
);

  reg meta_q;

  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      meta_q <= 1'b0;
      q_o <= 1'b0;
    end
    else
    begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule // flfr_sync2

`default_nettype wire

// >>> hw/flfr_ptr_track.v
/*
  Pointer tracker: write pointer in conversion clock cycles, stepped per
  data word; read pointer stepped each cycle, repositioned on a FIFO reset.
  Assumes one conversion clock per clk_i and a one-cycle word strobe.
*/
`timescale 1ns/10ps
`default_nettype none
`include "flfr_regs.vh"

module flfr_ptr_track (
  input wire clk_i,            // conversion clock
  input wire resetn_i,         // async reset, active low
  input wire word_stb_i,       // input data word written
  input wire [1:0] interp_i,   // interpolation select
  input wire fifo_reset_i,     // reposition pulse
  input wire [2:0] int_req_i,  // integral level request
  input wire [2:0] frac_req_i, // fractional level request
  output reg [2:0] int_rpt_o,  // measured integral level
  output reg [2:0] frac_rpt_o  // measured fractional level
);

  reg [5:0] wr_pos_q;   // write position in conversion cycles
  reg [5:0] rd_pos_q;   // read position in conversion cycles
  reg [5:0] phase_q;    // conversion cycles since the last word
  reg aligned_q;        // pointers placed by a FIFO reset
  reg [5:0] sep;
  reg [5:0] lvl;
  reg [5:0] frac_lvl;
  reg [5:0] target;
  reg [1:0] shift;

  // cycles per data word is 2, 4 or 8
  function [1:0] rate_shift;
    input [1:0] sel;
    begin
      case (sel)
        `FLFR_INTERP_4X: rate_shift = 2'd2;
        `FLFR_INTERP_8X: rate_shift = 2'd3;
        default: rate_shift = 2'd1;
      endcase
    end
  endfunction

  always @*
  begin
    shift = rate_shift(interp_i);
    target = ({3'h0, int_req_i} << shift) + {3'h0, frac_req_i};
    // write position advanced between word strobes
    sep = wr_pos_q + phase_q - rd_pos_q;
    lvl = sep >> shift;
    frac_lvl = sep & ((6'h01 << shift) - 6'h01);
  end

  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wr_pos_q <= 6'h00;
      rd_pos_q <= 6'h00;
      phase_q <= 6'h00;
      aligned_q <= 1'b0;
      int_rpt_o <= 3'h0;
      frac_rpt_o <= 3'h0;
    end
    else
    begin
      if (word_stb_i)
      begin
        wr_pos_q <= wr_pos_q + (6'h01 << shift);
        phase_q <= 6'h00;
      end
      else
        phase_q <= phase_q + 6'h01;
      // one cycle added: the write position also advances on this edge
      if (fifo_reset_i)
      begin
        rd_pos_q <= wr_pos_q + phase_q - target + 6'h01;
        aligned_q <= 1'b1;
      end
      else
        rd_pos_q <= rd_pos_q + 6'h01;
      // reports read zero until the pointers have been placed
      int_rpt_o <= aligned_q ? lvl[2:0] : 3'h0;
      frac_rpt_o <= aligned_q ? frac_lvl[2:0] : 3'h0;
    end
  end

endmodule // flfr_ptr_track

`default_nettype wire

// >>> hw/flfr_ctrl.v
/*
  FIFO level and frame reset control: register port, frame pulse
  response, host FIFO reset request and level readback.
  Assumes a synchronous register port on clk_i and an asynchronous
  frame pulse pin from the external data source.
*/
`timescale 1ns/10ps
`default_nettype none
`include "flfr_regs.vh"

module flfr_ctrl (
  input wire clk_i,              // conversion clock, 50 MHz
  input wire resetn_i,           // async reset, active low
  input wire reg_wr_i,           // register write strobe
  input wire reg_rd_i,           // register read strobe
  input wire [7:0] reg_addr_i,   // register address
  input wire [7:0] reg_wdata_i,  // register write data
  input wire [1:0] interp_i,     // interpolation select
  input wire frame_pin_i,        // frame pulse pin, asynchronous
  input wire word_stb_i,         // input word strobe, same clock
  output reg [7:0] reg_rdata_o,  // register read data
  output reg reg_rvalid_o,       // read data valid
  output reg fifo_reset_o,       // FIFO reset pulse
  output reg osc_reset_o,        // oscillator reset pulse
  output reg [2:0] int_rpt_o,    // measured integral level
  output reg [2:0] frac_rpt_o    // measured fractional level
);

  // ----------------------------------------------------------------
  // state machine codes
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_BUSY = 3'b010;
  localparam [2:0] ST_ACK = 3'b100;

  reg repeat_frame_response_q;
  reg [1:0] target_q;
  reg frame_ack_q;
  reg frame_done_q;
  reg [2:0] int_req_q;
  reg [2:0] frac_req_q;
  reg host_req_q;
  reg [2:0] host_st_q;
  reg [2:0] host_st_d;
  reg host_ack;
  reg frame_prev_q;
  wire frame_sync;
  wire frame_edge;
  wire frame_act;
  wire host_fire;
  wire fifo_rst_d;
  wire osc_rst_d;
  wire [2:0] trk_int;
  wire [2:0] trk_frac;
  wire wr_frame;
  wire wr_level;
  wire wr_fifo;

  // ----------------------------------------------------------------
  // frame pulse synchronisation
  // ----------------------------------------------------------------
  flfr_sync2 u_frame_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i(frame_pin_i),
    .q_o(frame_sync)
  );

  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      frame_prev_q <= 1'b0;
    else
      frame_prev_q <= frame_sync;
  end

  assign frame_edge = frame_sync & ~frame_prev_q;
  assign frame_act = frame_edge & (repeat_frame_response_q | ~frame_done_q);

  // ----------------------------------------------------------------
  // reset targets
  // ----------------------------------------------------------------
  function tgt_fifo;
    input [1:0] t;
    begin
      tgt_fifo = (t == `FLFR_TGT_FIFO) || (t == `FLFR_TGT_BOTH);
    end
  endfunction

  function tgt_osc;
    input [1:0] t;
    begin
      tgt_osc = (t == `FLFR_TGT_OSC) || (t == `FLFR_TGT_BOTH);
    end
  endfunction

  assign host_fire = (host_st_q == ST_IDLE) & host_req_q;
  assign fifo_rst_d = (frame_act & tgt_fifo(target_q)) | host_fire;
  assign osc_rst_d = frame_act & tgt_osc(target_q);

  // ----------------------------------------------------------------
  // host reset request sequencing
  // ----------------------------------------------------------------
  always @*
  begin
    host_st_d = host_st_q;
    host_ack = 1'b0;
    case (host_st_q)
      ST_IDLE:
      begin
        if (host_req_q)
          host_st_d = ST_BUSY;
      end
      ST_BUSY:
      begin
        host_st_d = ST_ACK;
      end
      ST_ACK:
      begin
        host_ack = 1'b1;
        if (!host_req_q)
          host_st_d = ST_IDLE;
      end
      default:
      begin
        host_st_d = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // register write decode
  // ----------------------------------------------------------------
  function wr_hit;
    input stb;
    input [7:0] addr;
    input [7:0] match;
    begin
      wr_hit = stb && (addr == match);
    end
  endfunction

  assign wr_frame = wr_hit(reg_wr_i, reg_addr_i, `FLFR_ADDR_FRAME_CTRL);
  assign wr_level = wr_hit(reg_wr_i, reg_addr_i, `FLFR_ADDR_LEVEL_REQ);
  assign wr_fifo = wr_hit(reg_wr_i, reg_addr_i, `FLFR_ADDR_FIFO_CTRL);

  // ----------------------------------------------------------------
  // frame reset control register
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      repeat_frame_response_q <= `FLFR_RST_REPEAT;
      target_q <= `FLFR_RST_TARGET;
    end
    else if (wr_frame)
    begin
      repeat_frame_response_q <= reg_wdata_i[`FLFR_REPEAT_BIT];
      target_q <= reg_wdata_i[`FLFR_TARGET_HI:`FLFR_TARGET_LO];
    end
  end

  // ----------------------------------------------------------------
  // level request register
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      int_req_q <= `FLFR_RST_INT_LEVEL;
      frac_req_q <= `FLFR_RST_FRAC_LEVEL;
    end
    else if (wr_level)
    begin
      int_req_q <= reg_wdata_i[`FLFR_INT_HI:`FLFR_INT_LO];
      frac_req_q <= reg_wdata_i[`FLFR_FRAC_HI:`FLFR_FRAC_LO];
    end
  end

  // ----------------------------------------------------------------
  // fifo reset control register
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      host_req_q <= 1'b0;
    end
    else if (wr_fifo)
    begin
      host_req_q <= reg_wdata_i[`FLFR_HOST_REQ_BIT];
    end
  end

  // ----------------------------------------------------------------
  // frame acknowledge
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      frame_ack_q <= 1'b0;
      frame_done_q <= 1'b0;
    end
    else if (frame_edge)
    begin
      frame_ack_q <= 1'b1;
      frame_done_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // reset pulses and host sequencer state
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      host_st_q <= ST_IDLE;
      fifo_reset_o <= 1'b0;
      osc_reset_o <= 1'b0;
    end
    else
    begin
      host_st_q <= host_st_d;
      fifo_reset_o <= fifo_rst_d;
      osc_reset_o <= osc_rst_d;
    end
  end

  // ----------------------------------------------------------------
  // pointer tracking
  // ----------------------------------------------------------------
  flfr_ptr_track u_track (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .word_stb_i(word_stb_i),
    .interp_i(interp_i),
    .fifo_reset_i(fifo_reset_o),
    .int_req_i(int_req_q),
    .frac_req_i(frac_req_q),
    .int_rpt_o(trk_int),
    .frac_rpt_o(trk_frac)
  );

  // ----------------------------------------------------------------
  // level report outputs
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      int_rpt_o <= 3'h0;
      frac_rpt_o <= 3'h0;
    end
    else
    begin
      int_rpt_o <= trk_int;
      frac_rpt_o <= trk_frac;
    end
  end

  // ----------------------------------------------------------------
  // readback
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
      begin
        case (reg_addr_i)
          `FLFR_ADDR_FRAME_CTRL:
            reg_rdata_o <= {4'h0, frame_ack_q, repeat_frame_response_q, target_q};
          `FLFR_ADDR_LEVEL_REQ:
            reg_rdata_o <= {1'b0, int_req_q, 1'b0, frac_req_q};
          `FLFR_ADDR_LEVEL_RPT:
            reg_rdata_o <= {1'b0, trk_int, 1'b0, trk_frac};
          `FLFR_ADDR_FIFO_CTRL:
            reg_rdata_o <= {6'h00, host_ack, host_req_q};
          default:
            reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

endmodule // flfr_ctrl

`default_nettype wire

// >>> verif/flfr_ctrl_assertions.sv
/* checker for the register port, reset pulses and frame response.
   bound into flfr_ctrl; sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module flfr_ctrl_chk (
  input wire logic clk_i, // clock
  input wire logic resetn_i, // reset, active low
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  input wire logic [7:0] reg_addr_i, // address
  input wire logic [7:0] reg_wdata_i, // write data
  input wire logic frame_pin_i, // frame pin
  input wire logic [7:0] reg_rdata_o, // read data
  input wire logic reg_rvalid_o, // read valid
  input wire logic fifo_reset_o, // fifo reset pulse
  input wire logic osc_reset_o // osc reset pulse
);
  // ----
  // shadows of writable fields
  // ----
  logic [7:0] fc_q;
  logic [7:0] lv_q;
  logic rq_q;
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      fc_q <= 8'h02;
      lv_q <= 8'h40;
      rq_q <= 1'b0;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == 8'h22) fc_q <= reg_wdata_i & 8'h07;
      if (reg_addr_i == 8'h23) lv_q <= reg_wdata_i & 8'h77;
      if (reg_addr_i == 8'h25) rq_q <= reg_wdata_i[0];
    end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  chk_rvalid_follows_read: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read valid missing");
  chk_rvalid_has_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
    else $error("read valid without read");
  chk_frame_ctrl_read: assert property (reg_rd_i && reg_addr_i == 8'h22 |=> reg_rdata_o[2:0] == $past(fc_q[2:0]))
    else $error("frame control readback wrong");
  chk_level_req_read: assert property (reg_rd_i && reg_addr_i == 8'h23 |=> (reg_rdata_o & 8'h77) == $past(lv_q))
    else $error("level request readback wrong");
  chk_host_req_read: assert property (reg_rd_i && reg_addr_i == 8'h25 |=> reg_rdata_o[0] == $past(rq_q))
    else $error("host request bit readback wrong");
  chk_host_reset_pulse: assert property (reg_wr_i && reg_addr_i == 8'h25 && reg_wdata_i[0] && !rq_q |-> ##2 fifo_reset_o)
    else $error("host fifo reset pulse missing");
  chk_osc_target_ok: assert property (osc_reset_o |-> $past(fc_q[1:0]) == 2'h1 || $past(fc_q[1:0]) == 2'h2)
    else $error("oscillator reset for wrong target");
  chk_osc_pulse_single: assert property (osc_reset_o |=> !osc_reset_o)
    else $error("oscillator reset longer than one cycle");
  chk_repeat_frame_acts: assert property ($rose(frame_pin_i) && fc_q[2] && fc_q[1:0] != 2'h3
    |-> ##[3:5] (fifo_reset_o || osc_reset_o))
    else $error("repeat frame pulse not acted on");
  cover property (osc_reset_o);
  cover property (fifo_reset_o && fc_q[2]);
  cover property (reg_rd_i && reg_addr_i == 8'h24);
endmodule // flfr_ctrl_chk
bind flfr_ctrl flfr_ctrl_chk u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .frame_pin_i(frame_pin_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .fifo_reset_o(fifo_reset_o), .osc_reset_o(osc_reset_o));
`default_nettype wire

// >>> verif/flfr_src.sv
/* external data source: word strobes at the input rate, frame pulses.
   assumes one conversion cycle per clk_i. */
`timescale 1ns/10ps
`default_nettype none
module flfr_src (
  input wire logic clk_i, // clock
  input wire logic [1:0] interp_i, // rate select
  output logic word_stb_o, // word strobe
  output logic frame_o // frame pin
);
  // ----
  // word pacing and frame pulses
  // ----
  int cnt = 0;
  initial word_stb_o = 1'b0;
  initial frame_o = 1'b0;
  always @(posedge clk_i)
  begin
    #1;
    cnt = (cnt + 1) % (interp_i == 2'h3 ? 8 : interp_i == 2'h2 ? 4 : 2);
    word_stb_o = (cnt == 0);
  end
  // pin held low three cycles after each pulse
  task send_frame();
    @(posedge clk_i);
    #1 frame_o = 1'b1;
    @(posedge clk_i);
    #1 frame_o = 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
endmodule // flfr_src
`default_nettype wire

// >>> verif/flfr_ctrl_tb.sv
/* self-checking bench of flfr_ctrl with the data source model.
   assumes flfr_src and the bound checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module flfr_ctrl_tb;
  // ----
  // signals, rows, instances
  // ----
  typedef struct {logic wen; logic [7:0] a, w, m, e;} flfr_row_t;
  flfr_row_t rows[9] = '{'{1'b0, 8'h22, 8'h00, 8'h0f, 8'h02}, '{1'b0, 8'h23, 8'h00, 8'hff, 8'h40},
    '{1'b0, 8'h24, 8'h00, 8'hff, 8'h00}, '{1'b0, 8'h25, 8'h00, 8'hff, 8'h00}, '{1'b1, 8'h22, 8'hff, 8'h0f, 8'h07},
    '{1'b1, 8'h23, 8'hff, 8'hff, 8'h77}, '{1'b1, 8'h30, 8'hff, 8'hff, 8'h00}, '{1'b1, 8'h23, 8'h40, 8'hff, 8'h40},
    '{1'b1, 8'h22, 8'h02, 8'h0f, 8'h02}};
  int rt[3] = '{2, 4, 8};
  logic [1:0] im[3] = '{2'h0, 2'h2, 2'h3};
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [1:0] interp_i = 2'h0;
  logic frame_pin_i, word_stb_i, reg_rvalid_o, fifo_reset_o, osc_reset_o;
  logic [7:0] reg_rdata_o, d;
  logic [2:0] int_rpt_o, frac_rpt_o;
  int fail_count = 0, samples_checked = 0, fc = 0, oc = 0, f, s, q;
  flfr_ctrl u_flfr_ctrl (.clk_i(clk_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .interp_i(interp_i), .frame_pin_i(frame_pin_i),
    .word_stb_i(word_stb_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .fifo_reset_o(fifo_reset_o),
    .osc_reset_o(osc_reset_o), .int_rpt_o(int_rpt_o), .frac_rpt_o(frac_rpt_o));
  flfr_src u_flfr_src (.clk_i(clk_i), .interp_i(interp_i), .word_stb_o(word_stb_i), .frame_o(frame_pin_i));
  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    fc <= fc + (fifo_reset_o === 1'b1);
    oc <= oc + (osc_reset_o === 1'b1);
  end
  task chk(input logic [7:0] g, e);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, w);
    @(posedge clk_i);
    #1 {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, w};
    @(posedge clk_i);
    #1 reg_wr_i = 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk_i);
    #1 {reg_rd_i, reg_addr_i} = {1'b1, a};
    @(posedge clk_i);
    #1 reg_rd_i = 1'b0;
    chk({7'h00, reg_rvalid_o}, 8'h01);
    d = reg_rdata_o;
  endtask
  task frame(input logic [7:0] ctl, ef, eo);
    int f0, o0;
    wr(8'h22, ctl);
    f0 = fc;
    o0 = oc;
    u_flfr_src.send_frame();
    repeat (4) @(posedge clk_i);
    chk(8'(fc - f0), ef);
    chk(8'(oc - o0), eo);
  endtask
  task complete_run;
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ----
  // main sequence
  // ----
  initial
  begin
    repeat (2) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    foreach (rows[i])
    begin
      if (rows[i].wen) wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk(d & rows[i].m, rows[i].e);
    end
    $display("test registers done");
    f = fc;
    wr(8'h25, 8'h01);
    repeat (3) @(posedge clk_i);
    chk(8'(fc - f), 8'h01);
    rd(8'h25);
    chk(d, 8'h03);
    wr(8'h25, 8'h00);
    rd(8'h25);
    chk(d, 8'h00);
    $display("test host reset done");
    foreach (rt[i])
    begin
      interp_i = im[i];
      // word pacing settles at the new rate before the reset
      repeat (10) @(posedge clk_i);
      wr(8'h23, {4'h4, 1'b0, 3'(rt[i] - 1)});
      wr(8'h25, 8'h01);
      wr(8'h25, 8'h00);
      repeat (30) @(posedge clk_i);
      rd(8'h24);
      s = d[6:4] * rt[i] + d[2:0];
      q = 5 * rt[i] - 1;
      chk({7'h00, s - q <= 2 && q - s <= 2}, 8'h01);
      s = int_rpt_o * rt[i] + frac_rpt_o;
      chk({7'h00, s - q <= 2 && q - s <= 2}, 8'h01);
    end
    interp_i = 2'h0;
    wr(8'h23, 8'h40);
    $display("test level readback done");
    frame(8'h00, 8'h01, 8'h00);
    rd(8'h22);
    chk(d & 8'h0f, 8'h08);
    frame(8'h01, 8'h00, 8'h00);
    frame(8'h04, 8'h01, 8'h00);
    frame(8'h05, 8'h00, 8'h01);
    frame(8'h06, 8'h01, 8'h01);
    frame(8'h07, 8'h00, 8'h00);
    $display("test frame response done");
    #1 resetn_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    rd(8'h22);
    chk(d & 8'h0f, 8'h02);
    $display("test second reset done");
    complete_run();
  end
endmodule // flfr_ctrl_tb
`default_nettype wire
